// file: src/dam_conn_pkg.sv
// Constants and types for the debug-side connection state machine.
// Assumes a 10 MHz system clock and pre-classified CC pin states.
// Notes on behaviour
// - Attach only when neither CC pin is open.
// - VCONN is never driven in any state.
// - Recovery drops CC terminations, then unattached state.
// - A directed recovery is taken from any state.
// - Without recovery, go to disabled or unattached.
// - Dead battery starts in sink unattached state.
// - Sink unattached and wait states: Rd, no VBUS.
// - Both pins seeing Rp starts sink attach wait.
// - Dual-role port toggles on timers or direction.
// - Open pin for debounce abandons sink attach wait.
// - Debounced pins plus VBUS attach sink or try.
// - Sink attached keeps Rd, leaves on VBUS loss.
// - Sink messaging only once sink attached.
// - Debug paths connect only in attached states.
// - Source unattached: Rp on both pins, no VBUS.
// - Both pins seeing Rd starts source attach wait.
// - Dual-role sequencing favours the source role.
// - Messaging needs determined orientation.
// - Debounced Rd and safe VBUS attach source.
// - VBUS follows the source attached state in time.
// - Try state attaches source or falls back.
package dam_conn_pkg;
  // ===========================================================
  // Timing
  // ===========================================================
  localparam int CLK_HZ = 10_000_000;
  localparam int T_ERR_REC_US = 25_000;
  localparam int T_PD_DEB_US = 10_000;
  localparam int T_CC_DEB_US = 100_000;
  localparam int T_TRY_CC_DEB_US = 10_000;
  localparam int T_DRP_TRY_US = 75_000;
  localparam int T_DRP_US = 75_000;
  localparam int DC_SRC_DRP_PCT = 50;
  localparam int ERR_REC_CYC = T_ERR_REC_US * (CLK_HZ / 1_000_000);
  localparam int PD_DEB_CYC = T_PD_DEB_US * (CLK_HZ / 1_000_000);
  localparam int CC_DEB_CYC = T_CC_DEB_US * (CLK_HZ / 1_000_000);
  localparam int TRY_CC_DEB_CYC = T_TRY_CC_DEB_US * (CLK_HZ / 1_000_000);
  localparam int DRP_TRY_CYC = T_DRP_TRY_US * (CLK_HZ / 1_000_000);
  localparam int DRP_SRC_CYC =
    T_DRP_US * (CLK_HZ / 1_000_000) / 100 * DC_SRC_DRP_PCT;
  localparam int DRP_SNK_CYC =
    T_DRP_US * (CLK_HZ / 1_000_000) / 100 * (100 - DC_SRC_DRP_PCT);
  localparam int TIMER_W = 24;

  // ===========================================================
  // Port kinds, CC classes and states
  // ===========================================================
  typedef enum logic [1:0] {
    KIND_SNK = 2'b00,
    KIND_SRC = 2'b01,
    KIND_DRP = 2'b10
  } port_kind_t;

  typedef enum logic [1:0] {
    CC_OPEN = 2'b00,
    CC_RD = 2'b01,
    CC_RP = 2'b10
  } cc_class_t;

  typedef enum logic [3:0] {
    ST_DISABLED = 4'h0,
    ST_ERR_REC = 4'h1,
    ST_UNATT_SNK = 4'h2,
    ST_WAIT_SNK = 4'h3,
    ST_ATT_SNK = 4'h4,
    ST_UNATT_SRC = 4'h5,
    ST_WAIT_SRC = 4'h6,
    ST_ATT_SRC = 4'h7,
    ST_TRY_SRC = 4'h8,
    ST_TRYWAIT_SNK = 4'h9
  } conn_state_t;
endpackage : dam_conn_pkg

// file: src/dam_timer_if.sv
// Interface between the state machine and its interval timer.
// Assumes a single clock domain.
`timescale 1ns/1ps
interface dam_timer_if;
  logic restart;
  logic [dam_conn_pkg::TIMER_W-1:0] count;
  modport ctrl (output restart, input count);
  modport tmr (input restart, output count);
endinterface : dam_timer_if

// file: src/dam_interval_timer.sv
// Saturating interval counter cleared by a restart request.
// Assumes restart is held in the cycle the qualifying condition changes.
`timescale 1ns/1ps
module dam_interval_timer #(
  parameter int WIDTH = dam_conn_pkg::TIMER_W
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic sys_rst_i,
  // Timer link
  dam_timer_if.tmr tif
);
  logic [WIDTH-1:0] cnt_reg;
  logic [WIDTH-1:0] cnt_next;
  wire logic at_max = &cnt_reg;

  initial begin
    if (WIDTH != dam_conn_pkg::TIMER_W) begin
      $error("Timer width must match the package width.");
    end
  end

  // ===========================================================
  // Counter
  // ===========================================================
  assign cnt_next = tif.restart ? '0 :
                    (at_max ? cnt_reg : cnt_reg + 1'b1);
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      cnt_reg <= '0;
    end else begin
      cnt_reg <= cnt_next;
    end
  end
  assign tif.count = cnt_reg;

  restart_clears_a: assert property (
    @(posedge clk_i) disable iff (sys_rst_i)
    tif.restart |=> cnt_reg == '0) else $error("Timer not cleared.");
endmodule : dam_interval_timer

// file: src/dam_conn_fsm.sv
// Debug-side connection state machine for Source, Sink and DRP ports.
// Assumes CC pin states are classified and synchronous to clk_i.
`timescale 1ns/1ps
module dam_conn_fsm #(
  parameter dam_conn_pkg::port_kind_t KIND = dam_conn_pkg::KIND_DRP,
  parameter bit HAS_ERR_REC = 1'b1,
  parameter bit HAS_DISABLED = 1'b1,
  parameter int ERR_REC_CYC = dam_conn_pkg::ERR_REC_CYC,
  parameter int PD_DEB_CYC = dam_conn_pkg::PD_DEB_CYC,
  parameter int CC_DEB_CYC = dam_conn_pkg::CC_DEB_CYC,
  parameter int TRY_CC_DEB_CYC = dam_conn_pkg::TRY_CC_DEB_CYC,
  parameter int DRP_TRY_CYC = dam_conn_pkg::DRP_TRY_CYC,
  parameter int DRP_SRC_CYC = dam_conn_pkg::DRP_SRC_CYC,
  parameter int DRP_SNK_CYC = dam_conn_pkg::DRP_SNK_CYC
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic sys_rst_i,
  // Line sensing
  input wire logic [1:0] cc1_class_i,
  input wire logic [1:0] cc2_class_i,
  input wire logic vbus_present_i,
  input wire logic vbus_safe0v_i,
  // Direction from system
  input wire logic recover_i,
  input wire logic disable_i,
  input wire logic toggle_i,
  input wire logic orient_known_i,
  // Terminations and power
  output logic cc_rd_en_o,
  output logic cc_rp_en_o,
  output logic vbus_drive_o,
  output logic vconn_drive_o,
  // Status
  output logic attached_o,
  output logic as_source_o,
  output logic debug_connect_o,
  output logic pd_allowed_o,
  output logic [3:0] state_o
);
  localparam int MAXC = (1 << dam_conn_pkg::TIMER_W) - 1;

  initial begin
    if (ERR_REC_CYC < 1 || PD_DEB_CYC < 1 || CC_DEB_CYC < 1 ||
        TRY_CC_DEB_CYC < 1 || DRP_TRY_CYC < 1 || DRP_SRC_CYC < 1 ||
        DRP_SNK_CYC < 1 || ERR_REC_CYC > MAXC || PD_DEB_CYC > MAXC ||
        CC_DEB_CYC > MAXC || DRP_TRY_CYC > MAXC || DRP_SRC_CYC > MAXC ||
        TRY_CC_DEB_CYC > MAXC || DRP_SNK_CYC > MAXC) begin
      $error("Timer counts out of range.");
    end
  end

  // ===========================================================
  // Pin decode
  // ===========================================================
  function automatic logic both_are(input logic [1:0] a,
                                    input logic [1:0] b,
                                    input dam_conn_pkg::cc_class_t c);
    both_are = (a == c) && (b == c);
  endfunction : both_are

  wire logic both_rp = both_are(cc1_class_i, cc2_class_i,
                                dam_conn_pkg::CC_RP);
  wire logic both_rd = both_are(cc1_class_i, cc2_class_i,
                                dam_conn_pkg::CC_RD);
  wire logic any_open = (cc1_class_i == dam_conn_pkg::CC_OPEN) ||
                        (cc2_class_i == dam_conn_pkg::CC_OPEN);
  wire logic is_drp = (KIND == dam_conn_pkg::KIND_DRP);
  wire logic is_snk = (KIND == dam_conn_pkg::KIND_SNK);

  // ===========================================================
  // State register and timer
  // ===========================================================
  dam_conn_pkg::conn_state_t state_reg;
  dam_conn_pkg::conn_state_t state_next;
  logic [3:0] qual_reg;
  logic [3:0] qual_next;
  dam_timer_if tif ();

  dam_interval_timer #(
    .WIDTH(dam_conn_pkg::TIMER_W)
  ) u_timer (
    .clk_i(clk_i),
    .sys_rst_i(sys_rst_i),
    .tif(tif)
  );

  wire logic [dam_conn_pkg::TIMER_W-1:0] t = tif.count;
  // Timer restarts on a state change or any change of the watched lines.
  assign qual_next = {both_rp, both_rd, any_open, vbus_present_i};
  assign tif.restart = (state_next != state_reg) ||
                       (qual_next != qual_reg);

  wire logic t_err = t >= (ERR_REC_CYC - 1);
  wire logic t_pd = t >= (PD_DEB_CYC - 1);
  wire logic t_cc = t >= (CC_DEB_CYC - 1);
  wire logic t_try_cc = t >= (TRY_CC_DEB_CYC - 1);
  wire logic t_try = t >= (DRP_TRY_CYC - 1);
  wire logic t_drp_src = t >= (DRP_SRC_CYC - 1);
  wire logic t_drp_snk = t >= (DRP_SNK_CYC - 1);
  wire dam_conn_pkg::conn_state_t unatt_home =
    is_snk ? dam_conn_pkg::ST_UNATT_SNK : dam_conn_pkg::ST_UNATT_SRC;
  wire dam_conn_pkg::conn_state_t src_drop =
    is_drp ? dam_conn_pkg::ST_UNATT_SNK : dam_conn_pkg::ST_UNATT_SRC;
  wire dam_conn_pkg::conn_state_t recover_to =
    HAS_ERR_REC ? dam_conn_pkg::ST_ERR_REC :
    (HAS_DISABLED ? dam_conn_pkg::ST_DISABLED : unatt_home);

  // ===========================================================
  // Next state
  // ===========================================================
  always_comb begin
    state_next = state_reg;
    if (recover_i) begin
      state_next = recover_to;
    end else if (disable_i && HAS_DISABLED) begin
      state_next = dam_conn_pkg::ST_DISABLED;
    end else begin
      case (state_reg)
        dam_conn_pkg::ST_DISABLED: begin
          state_next = unatt_home;
        end
        dam_conn_pkg::ST_ERR_REC: begin
          if (t_err) begin
            state_next = unatt_home;
          end
        end
        dam_conn_pkg::ST_UNATT_SNK: begin
          if (both_rp) begin
            state_next = dam_conn_pkg::ST_WAIT_SNK;
          end else if (is_drp && (toggle_i || (any_open && t_drp_snk))) begin
            state_next = dam_conn_pkg::ST_UNATT_SRC;
          end
        end
        dam_conn_pkg::ST_WAIT_SNK: begin
          if (any_open && t_pd) begin
            state_next = src_drop == dam_conn_pkg::ST_UNATT_SNK ?
                         dam_conn_pkg::ST_UNATT_SRC :
                         dam_conn_pkg::ST_UNATT_SNK;
          end else if (!any_open && vbus_present_i && t_cc) begin
            state_next = is_drp ? dam_conn_pkg::ST_TRY_SRC :
                         dam_conn_pkg::ST_ATT_SNK;
          end
        end
        dam_conn_pkg::ST_ATT_SNK: begin
          if (!vbus_present_i) begin
            state_next = dam_conn_pkg::ST_UNATT_SNK;
          end
        end
        dam_conn_pkg::ST_UNATT_SRC: begin
          if (both_rd) begin
            state_next = dam_conn_pkg::ST_WAIT_SRC;
          end else if (is_drp && (toggle_i || t_drp_src)) begin
            state_next = dam_conn_pkg::ST_UNATT_SNK;
          end
        end
        dam_conn_pkg::ST_WAIT_SRC: begin
          if (any_open) begin
            state_next = src_drop;
          end else if (both_rd && vbus_safe0v_i && t_cc) begin
            state_next = dam_conn_pkg::ST_ATT_SRC;
          end
        end
        dam_conn_pkg::ST_ATT_SRC: begin
          if (any_open) begin
            state_next = src_drop;
          end
        end
        dam_conn_pkg::ST_TRY_SRC: begin
          if (both_rd && t_try_cc) begin
            state_next = dam_conn_pkg::ST_ATT_SRC;
          end else if (!both_rd && t_try) begin
            state_next = dam_conn_pkg::ST_TRYWAIT_SNK;
          end
        end
        dam_conn_pkg::ST_TRYWAIT_SNK: begin
          if (!any_open && vbus_present_i && t_cc) begin
            state_next = dam_conn_pkg::ST_ATT_SNK;
          end else if ((any_open || !vbus_present_i) && t_pd) begin
            state_next = dam_conn_pkg::ST_UNATT_SNK;
          end
        end
        default: begin
          state_next = unatt_home;
        end
      endcase
    end
  end

  // Reset lands in the sink unattached state so an unpowered start waits.
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      state_reg <= dam_conn_pkg::ST_UNATT_SNK;
      qual_reg <= 4'h0;
    end else begin
      state_reg <= state_next;
      qual_reg <= qual_next;
    end
  end

  // ===========================================================
  // Outputs
  // ===========================================================
  wire logic in_snk_term = (state_reg == dam_conn_pkg::ST_UNATT_SNK) ||
                           (state_reg == dam_conn_pkg::ST_WAIT_SNK) ||
                           (state_reg == dam_conn_pkg::ST_ATT_SNK) ||
                           (state_reg == dam_conn_pkg::ST_TRYWAIT_SNK);
  wire logic in_src_term = (state_reg == dam_conn_pkg::ST_UNATT_SRC) ||
                           (state_reg == dam_conn_pkg::ST_WAIT_SRC) ||
                           (state_reg == dam_conn_pkg::ST_ATT_SRC) ||
                           (state_reg == dam_conn_pkg::ST_TRY_SRC);
  wire logic att = (state_reg == dam_conn_pkg::ST_ATT_SNK) ||
                   (state_reg == dam_conn_pkg::ST_ATT_SRC);
  logic rd_reg;
  logic rp_reg;
  logic vbus_reg;
  logic att_reg;
  logic src_reg;
  logic pd_reg;

  // Registered outputs lag the state by one cycle.
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      rd_reg <= 1'b1;
      rp_reg <= 1'b0;
      vbus_reg <= 1'b0;
      att_reg <= 1'b0;
      src_reg <= 1'b0;
      pd_reg <= 1'b0;
    end else begin
      rd_reg <= in_snk_term;
      rp_reg <= in_src_term;
      vbus_reg <= (state_reg == dam_conn_pkg::ST_ATT_SRC);
      att_reg <= att;
      src_reg <= (state_reg == dam_conn_pkg::ST_ATT_SRC);
      pd_reg <= att && orient_known_i;
    end
  end

  assign cc_rd_en_o = rd_reg;
  assign cc_rp_en_o = rp_reg;
  assign vbus_drive_o = vbus_reg;
  assign vconn_drive_o = 1'b0;
  assign attached_o = att_reg;
  assign as_source_o = src_reg;
  assign debug_connect_o = att_reg;
  assign pd_allowed_o = pd_reg;
  assign state_o = state_reg;

  // ===========================================================
  // Checks
  // ===========================================================
  vconn_off_a: assert property (
    @(posedge clk_i) disable iff (sys_rst_i)
    !vconn_drive_o) else $error("VCONN driven.");
  err_noterm_a: assert property (
    @(posedge clk_i) disable iff (sys_rst_i)
    $past(state_reg == dam_conn_pkg::ST_ERR_REC) |->
    !cc_rd_en_o && !cc_rp_en_o) else $error("Terms in recovery.");
  recover_taken_a: assert property (
    @(posedge clk_i) disable iff (sys_rst_i)
    recover_i && HAS_ERR_REC |=> state_reg == dam_conn_pkg::ST_ERR_REC)
    else $error("Recovery ignored.");
  snk_term_a: assert property (
    @(posedge clk_i) disable iff (sys_rst_i)
    $past(state_reg == dam_conn_pkg::ST_WAIT_SNK) |->
    cc_rd_en_o && !vbus_drive_o) else $error("Bad sink term.");
  snk_wait_entry_a: assert property (
    @(posedge clk_i) disable iff (sys_rst_i)
    state_reg == dam_conn_pkg::ST_UNATT_SNK && !recover_i && !disable_i &&
    both_rp |=> state_reg == dam_conn_pkg::ST_WAIT_SNK)
    else $error("Sink wait missed.");
  vbus_loss_a: assert property (
    @(posedge clk_i) disable iff (sys_rst_i)
    state_reg == dam_conn_pkg::ST_ATT_SNK && !vbus_present_i && !recover_i
    && !disable_i |=> state_reg == dam_conn_pkg::ST_UNATT_SNK)
    else $error("VBUS loss missed.");
  dbg_attached_a: assert property (
    @(posedge clk_i) disable iff (sys_rst_i)
    debug_connect_o |-> $past(att)) else $error("Early debug.");
  pd_orient_a: assert property (
    @(posedge clk_i) disable iff (sys_rst_i)
    pd_allowed_o |-> $past(orient_known_i) && attached_o)
    else $error("Messaging early.");
  src_wait_entry_a: assert property (
    @(posedge clk_i) disable iff (sys_rst_i)
    state_reg == dam_conn_pkg::ST_UNATT_SRC && both_rd && !recover_i &&
    !disable_i |=> state_reg == dam_conn_pkg::ST_WAIT_SRC)
    else $error("Source wait missed.");
  vbus_follow_a: assert property (
    @(posedge clk_i) disable iff (sys_rst_i)
    $rose(state_reg == dam_conn_pkg::ST_ATT_SRC) |=> vbus_drive_o)
    else $error("VBUS late.");
  single_pin_a: assert property (
    @(posedge clk_i) disable iff (sys_rst_i)
    state_reg == dam_conn_pkg::ST_UNATT_SNK && !both_rp |=>
    state_reg != dam_conn_pkg::ST_WAIT_SNK)
    else $error("Single pin attach.");

  // ===========================================================
  // Transition checks
  // ===========================================================
  err_exit_a: assert property (
    @(posedge clk_i) disable iff (sys_rst_i)
    state_reg == dam_conn_pkg::ST_ERR_REC && t_err && !recover_i &&
    !disable_i |=> state_reg == (is_snk ? dam_conn_pkg::ST_UNATT_SNK :
    dam_conn_pkg::ST_UNATT_SRC)) else $error("Recovery stuck.");
  snk_toggle_a: assert property (
    @(posedge clk_i) disable iff (sys_rst_i)
    is_drp && state_reg == dam_conn_pkg::ST_UNATT_SNK && toggle_i &&
    !both_rp && !recover_i && !disable_i |=>
    state_reg == dam_conn_pkg::ST_UNATT_SRC) else $error("Toggle lost.");
  src_toggle_a: assert property (
    @(posedge clk_i) disable iff (sys_rst_i)
    is_drp && state_reg == dam_conn_pkg::ST_UNATT_SRC && t_drp_src &&
    !both_rd && !recover_i && !disable_i |=>
    state_reg == dam_conn_pkg::ST_UNATT_SNK) else $error("Source share.");
  snk_open_a: assert property (
    @(posedge clk_i) disable iff (sys_rst_i)
    state_reg == dam_conn_pkg::ST_WAIT_SNK && any_open && t_pd &&
    !recover_i && !disable_i |=> state_reg == (is_drp ?
    dam_conn_pkg::ST_UNATT_SRC : dam_conn_pkg::ST_UNATT_SNK))
    else $error("Open pin kept.");
  snk_attach_a: assert property (
    @(posedge clk_i) disable iff (sys_rst_i)
    state_reg == dam_conn_pkg::ST_WAIT_SNK && !any_open && vbus_present_i &&
    t_cc && !recover_i && !disable_i |=> state_reg == (is_drp ?
    dam_conn_pkg::ST_TRY_SRC : dam_conn_pkg::ST_ATT_SNK))
    else $error("Sink attach missed.");
  src_term_a: assert property (
    @(posedge clk_i) disable iff (sys_rst_i)
    $past(state_reg == dam_conn_pkg::ST_UNATT_SRC) |->
    cc_rp_en_o && !cc_rd_en_o && !vbus_drive_o) else $error("Bad src term.");
  src_open_a: assert property (
    @(posedge clk_i) disable iff (sys_rst_i)
    state_reg == dam_conn_pkg::ST_WAIT_SRC && any_open && !recover_i &&
    !disable_i |=> state_reg == (is_drp ? dam_conn_pkg::ST_UNATT_SNK :
    dam_conn_pkg::ST_UNATT_SRC)) else $error("Source open kept.");
  vbus_off_a: assert property (
    @(posedge clk_i) disable iff (sys_rst_i)
    $fell(state_reg == dam_conn_pkg::ST_ATT_SRC) |=> !vbus_drive_o)
    else $error("VBUS stays on.");
  try_attach_a: assert property (
    @(posedge clk_i) disable iff (sys_rst_i)
    state_reg == dam_conn_pkg::ST_TRY_SRC && both_rd && t_try_cc &&
    !recover_i && !disable_i |=> state_reg == dam_conn_pkg::ST_ATT_SRC)
    else $error("Try attach missed.");
  try_fallback_a: assert property (
    @(posedge clk_i) disable iff (sys_rst_i)
    state_reg == dam_conn_pkg::ST_TRY_SRC && !both_rd && t_try &&
    !recover_i && !disable_i |=> state_reg == dam_conn_pkg::ST_TRYWAIT_SNK)
    else $error("Try fallback missed.");

  snk_attach_c: cover property (@(posedge clk_i)
    $rose(state_reg == dam_conn_pkg::ST_ATT_SNK));
  src_attach_c: cover property (@(posedge clk_i)
    $rose(state_reg == dam_conn_pkg::ST_ATT_SRC));
  trywait_c: cover property (@(posedge clk_i)
    $rose(state_reg == dam_conn_pkg::ST_TRYWAIT_SNK));
  recover_c: cover property (@(posedge clk_i)
    $fell(state_reg == dam_conn_pkg::ST_ERR_REC));
  disabled_c: cover property (@(posedge clk_i)
    $rose(state_reg == dam_conn_pkg::ST_DISABLED));
endmodule : dam_conn_fsm

// file: verification/ts_port_model.sv
// Behavioural target port at the far side of the CC and VBUS lines.
// Assumes the bench picks the target's terminations through mode_i.
`timescale 1ns/1ps
module ts_port_model (
  // Clock
  input wire logic clk_i,
  // Target kind: 0 none, 1 source, 2 sink, 3 sink on cc1, 4 source no VBUS
  input wire logic [2:0] mode_i,
  // Debug-side terminations and power
  input wire logic rd_en_i,
  input wire logic rp_en_i,
  input wire logic vbus_drive_i,
  // Sensed lines
  output logic [1:0] cc1_class_o,
  output logic [1:0] cc2_class_o,
  output logic vbus_present_o,
  output logic vbus_safe0v_o
);
  // ==========================================================
  // Line levels
  // ==========================================================
  // The target never drives VCONN, so the model has no such line.
  initial begin
    cc1_class_o = dam_conn_pkg::CC_OPEN;
    cc2_class_o = dam_conn_pkg::CC_OPEN;
    vbus_present_o = 1'b0;
    vbus_safe0v_o = 1'b1;
  end
  // A target source powers VBUS only while it sees Rd from us.
  // Updates after the bench has settled its mode for this cycle.
  always @(posedge clk_i) begin
    #2;
    cc1_class_o = ((mode_i == 3'h1 || mode_i == 3'h4) && rd_en_i) ?
      dam_conn_pkg::CC_RP : ((mode_i == 3'h2 || mode_i == 3'h3) &&
      rp_en_i) ? dam_conn_pkg::CC_RD : dam_conn_pkg::CC_OPEN;
    cc2_class_o = ((mode_i == 3'h1 || mode_i == 3'h4) && rd_en_i) ?
      dam_conn_pkg::CC_RP : (mode_i == 3'h2 && rp_en_i) ?
      dam_conn_pkg::CC_RD : dam_conn_pkg::CC_OPEN;
    vbus_present_o = (mode_i == 3'h1 && rd_en_i) || vbus_drive_i;
    vbus_safe0v_o = !vbus_present_o;
  end
endmodule : ts_port_model

// file: verification/tb.sv
// Self-checking bench for the DRP variant of the connection machine.
// Assumes the target model drives the sensed lines after each edge.
`timescale 1ns/1ps
module tb;
  localparam int ERR = 6;
  localparam int PDD = 5;
  localparam int CCD = 8;
  localparam int TRY = 12;
  localparam int TGL = 10;
  logic clk_i, sys_rst_i, rec, dis, tog, orient;
  logic [2:0] mode;
  logic [1:0] cc1, cc2;
  logic vbus, safe0v, rd_en, rp_en, vbus_drv, vconn, att, src, dbg, pd;
  logic [3:0] st;
  int n_fail = 0;
  int checks = 0;
  int n;

  dam_conn_fsm #(.KIND(dam_conn_pkg::KIND_DRP), .ERR_REC_CYC(ERR),
    .PD_DEB_CYC(PDD), .CC_DEB_CYC(CCD), .TRY_CC_DEB_CYC(PDD),
    .DRP_TRY_CYC(TRY), .DRP_SRC_CYC(TGL), .DRP_SNK_CYC(TGL))
  dam_conn_fsm_i (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
    .cc1_class_i(cc1), .cc2_class_i(cc2), .vbus_present_i(vbus),
    .vbus_safe0v_i(safe0v), .recover_i(rec), .disable_i(dis),
    .toggle_i(tog), .orient_known_i(orient), .cc_rd_en_o(rd_en),
    .cc_rp_en_o(rp_en), .vbus_drive_o(vbus_drv), .vconn_drive_o(vconn),
    .attached_o(att), .as_source_o(src), .debug_connect_o(dbg),
    .pd_allowed_o(pd), .state_o(st));

  ts_port_model ts_port_model_i (.clk_i(clk_i), .mode_i(mode),
    .rd_en_i(rd_en), .rp_en_i(rp_en), .vbus_drive_i(vbus_drv),
    .cc1_class_o(cc1), .cc2_class_o(cc2), .vbus_present_o(vbus),
    .vbus_safe0v_o(safe0v));

  // ==========================================================
  // Helpers
  // ==========================================================
  initial begin
    clk_i = 1'b0;
    forever #50 clk_i = ~clk_i;
  end

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : end_of_test

  task automatic check(input string what, input logic [3:0] exp,
                       input logic [3:0] got);
    checks++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  task automatic tick(input int k);
    repeat (k) @(posedge clk_i);
    #1;
  endtask : tick

  task automatic wait_state(input logic [3:0] s, input int lim);
    n = 0;
    while (st !== s && n < lim) begin
      tick(1);
      n++;
    end
    if (st !== s) begin
      n_fail++;
      $display("MISMATCH state wait expected %h seen %h", s, st);
      end_of_test();
    end
  endtask : wait_state

  function automatic logic [3:0] near(input int k, input int lo,
                                      input int hi);
    return {3'h0, (k >= lo && k <= hi)};
  endfunction : near

  // ==========================================================
  // Scenarios
  // ==========================================================
  task automatic t_reset();
    check("reset state", 4'h2, st);
    check("reset rd", 4'h1, {3'h0, rd_en});
    check("reset rp", 4'h0, {3'h0, rp_en});
    check("reset vbus", 4'h0, {3'h0, vbus_drv});
    check("vconn", 4'h0, {3'h0, vconn});
    $display("done reset");
  endtask : t_reset

  task automatic t_toggle();
    wait_state(4'h5, TGL + 5);
    check("snk share", 4'h1, near(n, TGL - 2, TGL + 2));
    tick(1);
    check("src rd", 4'h0, {3'h0, rd_en});
    check("src rp", 4'h1, {3'h0, rp_en});
    check("src vbus", 4'h0, {3'h0, vbus_drv});
    wait_state(4'h2, TGL + 5);
    check("src share", 4'h1, near(n, TGL - 3, TGL + 2));
    tog = 1'b1;
    tick(1);
    tog = 1'b0;
    wait_state(4'h5, 3);
    dis = 1'b1;
    wait_state(4'h0, 3);
    tick(1);
    check("dis terms", 4'h0, {2'h0, rd_en, rp_en});
    dis = 1'b0;
    tick(3);
    check("dis left", 4'h5, st);
    $display("done toggle");
  endtask : t_toggle

  task automatic t_single();
    logic bad;
    bad = 1'b0;
    mode = 3'h3;
    repeat (60) begin
      tick(1);
      bad = bad | (att !== 1'b0) | (st === 4'h6) | (st === 4'h3);
    end
    check("single pin", 4'h0, {3'h0, bad});
    mode = 3'h0;
    $display("done single");
  endtask : t_single

  task automatic t_source();
    mode = 3'h2;
    wait_state(4'h6, 40);
    check("wait dbg", 4'h0, {3'h0, dbg});
    wait_state(4'h7, CCD + 5);
    check("rd debounce", 4'h1, near(n, CCD - 2, CCD + 2));
    tick(2);
    check("src vbus on", 4'h1, {3'h0, vbus_drv});
    check("src att", 4'h3, {2'h0, src, dbg});
    check("no orient", 4'h0, {3'h0, pd});
    orient = 1'b1;
    tick(2);
    check("orient pd", 4'h1, {3'h0, pd});
    orient = 1'b0;
    rec = 1'b1;
    tick(1);
    rec = 1'b0;
    wait_state(4'h1, 3);
    tick(1);
    check("rec terms", 4'h0, {1'h0, rd_en, rp_en, vbus_drv});
    wait_state(4'h5, ERR + 4);
    check("rec time", 4'h1, near(n, ERR - 3, ERR + 2));
    mode = 3'h0;
    wait_state(4'h2, 40);
    $display("done source");
  endtask : t_source

  task automatic t_sink();
    mode = 3'h4;
    wait_state(4'h3, 5);
    mode = 3'h0;
    wait_state(4'h5, PDD + 5);
    check("open debounce", 4'h1, near(n, PDD - 2, PDD + 3));
    mode = 3'h1;
    wait_state(4'h8, 60);
    check("try no att", 4'h0, {3'h0, att});
    wait_state(4'h9, TRY + 4);
    check("try time", 4'h1, near(n, TRY - 3, TRY + 3));
    wait_state(4'h4, CCD + 6);
    tick(2);
    check("snk att", 4'h5, {1'h0, att, src, dbg});
    check("snk rd", 4'h2, {2'h0, rd_en, vbus_drv});
    orient = 1'b1;
    tick(2);
    check("snk pd", 4'h1, {3'h0, pd});
    mode = 3'h4;
    wait_state(4'h2, 4);
    tick(1);
    check("snk gone", 4'h0, {2'h0, att, pd});
    orient = 1'b0;
    $display("done sink");
  endtask : t_sink

  initial begin
    sys_rst_i = 1'b1;
    rec = 1'b0;
    dis = 1'b0;
    tog = 1'b0;
    orient = 1'b0;
    mode = 3'h0;
    tick(20);
    sys_rst_i = 1'b0;
    tick(1);
    t_reset();
    t_toggle();
    t_single();
    t_source();
    t_sink();
    end_of_test();
  end
endmodule : tb
